// ---- include/dll_ctrl_pkg.sv ----
// constants for the dll mode, clock change and write leveling control block
// assumes mode register writes arrive already decoded on the core clock
package dll_ctrl_pkg;

  // ----------------------------------------
  // mode register selection and bit positions
  // ----------------------------------------
  localparam logic [1:0] MR0_SEL      = 2'h0;
  localparam logic [1:0] MR1_SEL      = 2'h1;
  localparam logic [1:0] MR2_SEL      = 2'h2;
  localparam int         ADDR_W       = 13;
  localparam int         DLL_OFF_BIT  = 0;
  localparam int         RTT_B0_BIT   = 2;
  localparam int         RTT_B1_BIT   = 6;
  localparam int         RTT_B2_BIT   = 9;
  localparam int         AL_LSB       = 3;
  localparam int         WL_EN_BIT    = 7;
  localparam int         QOFF_BIT     = 12;
  localparam int         CL_LSB       = 4;
  localparam int         DLL_RST_BIT  = 8;
  localparam int         CWL_LSB      = 3;

  // ----------------------------------------
  // latency encodings and reset values
  // ----------------------------------------
  localparam logic [3:0] CL_BASE      = 4'h4;
  localparam logic [3:0] CWL_BASE     = 4'h5;
  localparam logic [3:0] CL_DLL_OFF   = 4'h6;
  localparam logic [3:0] CWL_DLL_OFF  = 4'h6;
  localparam logic [3:0] CL_RESET     = 4'h6;
  localparam logic [3:0] CWL_RESET    = 4'h6;
  localparam logic [1:0] AL_CL_M1     = 2'h1;
  localparam logic [1:0] AL_CL_M2     = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          TCKSRE_NS     = 10;
  localparam int          TCKSRE_CYC_I  = (TCKSRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  TCKSRE_CYC    = 4'((TCKSRE_CYC_I < 1) ? 1 : TCKSRE_CYC_I);
  localparam logic [9:0]  TDLLK_NCK     = 10'h200;

  // ----------------------------------------
  // synchronised pin channels
  // ----------------------------------------
  localparam int NPINS    = 5;
  localparam int PIN_CK   = 0;
  localparam int PIN_DQSL = 1;
  localparam int PIN_DQSU = 2;
  localparam int PIN_CKE  = 3;
  localparam int PIN_ODT  = 4;

  typedef enum logic [1:0] {LP_ACTIVE, LP_SELF_REFRESH, LP_POWER_DOWN} lp_e;

endpackage

// ---- include/pin_sync_if.sv ----
// carries one asynchronous pin into the core clock domain and its filtered edges back
// assumes one pin_sync instance drives the sync side
`timescale 1ns/1ps
interface pin_sync_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport sync (input raw, output level, rise, fall);
  modport user (output raw, input level, rise, fall);
endinterface

// ---- src/pin_sync.sv ----
// three-flop synchroniser with agreement filter for one asynchronous pin
// assumes the pin is slower than half the core clock
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  pin_sync_if.sync  port
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  // the level only moves once the second and third stage agree
  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= port.raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign port.level = lvl_q;
  assign port.rise  = lvl_d & ~lvl_q;
  assign port.fall  = ~lvl_d & lvl_q;
endmodule

// ---- src/dll_mode_ctrl.sv ----
// dll on/off mode, clock change and write leveling control of the memory device
// assumes commands arrive decoded on the core clock; ck, strobes, cke and odt are raw pins
// Behaviour
// - mode register 1 bit 0 high turns the dll off until written low
// - dll-off supports only read and write latency six; others flagged
// - dll-off read strobe window opens one clock earlier than al plus cl
// - dll enable then mode register 0 bit 8 starts a dll reset
// - device ignores the clock once in low power and entry time passed
// - in power-down termination stays off when nominal termination disabled
// - leveling samples ck on each strobe rise and reports it on dq
// - leveling terminates strobes per odt, never the dq lines
// - each byte lane reports its own strobe to clock relation
// - mode register 1 bit 7 enters and leaves write leveling
`timescale 1ns/1ps
module dll_mode_ctrl
  import dll_ctrl_pkg::*;
(
  input  wire logic                             clock,
  input  wire logic                             sys_rst,
  input  wire logic                             mrs_valid,
  input  wire logic [1:0]                       mrs_sel,
  input  wire logic [dll_ctrl_pkg::ADDR_W-1:0]  mrs_addr,
  input  wire logic                             sre_cmd,
  input  wire logic                             read_cmd,
  input  wire logic                             ck_pin,
  input  wire logic                             cke_pin,
  input  wire logic                             odt_pin,
  input  wire logic                             dqs_l_pin,
  input  wire logic                             dqs_u_pin,
  input  wire logic [15:0]                      dq_i,
  output logic      [15:0]                      dq_o,
  output logic                                  dq_oe_n,
  output logic                                  dll_enabled,
  output logic                                  dll_locked,
  output logic                                  latency_error,
  output logic                                  leveling_active,
  output logic                                  clock_ignored,
  output logic                                  dq_term_on,
  output logic                                  dqs_term_on,
  output logic                                  read_window_start
);
  import dll_ctrl_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pin_sync_if pins[NPINS] ();
  logic [NPINS-1:0] pin_raw;
  assign pin_raw = {odt_pin, cke_pin, dqs_u_pin, dqs_l_pin, ck_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      assign pins[gi].raw = pin_raw[gi];
      pin_sync u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .port    (pins[gi])
      );
    end
  endgenerate

  logic ck_lvl, ck_rise, dqsl_rise, dqsu_rise, cke_rise, cke_fall, odt_lvl;
  assign ck_lvl    = pins[PIN_CK].level;
  assign ck_rise   = pins[PIN_CK].rise;
  assign dqsl_rise = pins[PIN_DQSL].rise;
  assign dqsu_rise = pins[PIN_DQSU].rise;
  assign cke_rise  = pins[PIN_CKE].rise;
  assign cke_fall  = pins[PIN_CKE].fall;
  assign odt_lvl   = pins[PIN_ODT].level;

  // ----------------------------------------
  // mode bits
  // ----------------------------------------
  logic       dll_off_q, dll_off_d, wl_q, wl_d, qoff_q, qoff_d, lat_err_q, lat_err_d;
  logic [2:0] rtt_q, rtt_d;
  logic [1:0] al_code_q, al_code_d;
  logic [3:0] cl_q, cl_d, cwl_q, cwl_d;
  logic       mr0_wr, mr1_wr, mr2_wr, dll_rst_start;

  assign mr0_wr        = mrs_valid && (mrs_sel == MR0_SEL);
  assign mr1_wr        = mrs_valid && (mrs_sel == MR1_SEL);
  assign mr2_wr        = mrs_valid && (mrs_sel == MR2_SEL);
  assign dll_rst_start = mr0_wr && mrs_addr[DLL_RST_BIT];

  always_comb begin
    dll_off_d = dll_off_q;
    wl_d      = wl_q;
    qoff_d    = qoff_q;
    rtt_d     = rtt_q;
    al_code_d = al_code_q;
    cl_d      = cl_q;
    cwl_d     = cwl_q;
    if (mr1_wr) begin
      dll_off_d = mrs_addr[DLL_OFF_BIT];
      wl_d      = mrs_addr[WL_EN_BIT];
      qoff_d    = mrs_addr[QOFF_BIT];
      rtt_d     = {mrs_addr[RTT_B2_BIT], mrs_addr[RTT_B1_BIT], mrs_addr[RTT_B0_BIT]};
      al_code_d = mrs_addr[AL_LSB +: 2];
    end
    if (mr0_wr) begin
      cl_d = CL_BASE + {1'b0, mrs_addr[CL_LSB +: 3]};
    end
    if (mr2_wr) begin
      cwl_d = CWL_BASE + {1'b0, mrs_addr[CWL_LSB +: 3]};
    end
    // dll-off only guarantees the single latency pair
    lat_err_d = dll_off_d && ((cl_d != CL_DLL_OFF) || (cwl_d != CWL_DLL_OFF));
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dll_off_q <= 1'b0;
      wl_q      <= 1'b0;
      qoff_q    <= 1'b0;
      rtt_q     <= 3'h0;
      al_code_q <= 2'h0;
      cl_q      <= CL_RESET;
      cwl_q     <= CWL_RESET;
      lat_err_q <= 1'b0;
    end else begin
      dll_off_q <= dll_off_d;
      wl_q      <= wl_d;
      qoff_q    <= qoff_d;
      rtt_q     <= rtt_d;
      al_code_q <= al_code_d;
      cl_q      <= cl_d;
      cwl_q     <= cwl_d;
      lat_err_q <= lat_err_d;
    end
  end

  // ----------------------------------------
  // low power state and clock ignore
  // ----------------------------------------
  lp_e        lp_q, lp_d;
  logic [3:0] sre_cnt_q, sre_cnt_d;
  logic       ign_q, ign_d;

  // counted on the core clock, since ck may stop once it is ignored
  always_comb begin
    lp_d      = lp_q;
    sre_cnt_d = sre_cnt_q;
    unique case (lp_q)
      LP_ACTIVE: begin
        if (sre_cmd) begin
          lp_d      = LP_SELF_REFRESH;
          sre_cnt_d = TCKSRE_CYC;
        end else if (cke_fall) begin
          lp_d      = LP_POWER_DOWN;
          sre_cnt_d = TCKSRE_CYC;
        end
      end
      LP_SELF_REFRESH, LP_POWER_DOWN: begin
        if (cke_rise) begin
          lp_d = LP_ACTIVE;
        end else if (sre_cnt_q != 4'h0) begin
          sre_cnt_d = sre_cnt_q - 4'h1;
        end
      end
    endcase
    ign_d = (lp_d != LP_ACTIVE) && (sre_cnt_d == 4'h0);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lp_q      <= LP_ACTIVE;
      sre_cnt_q <= 4'h0;
      ign_q     <= 1'b0;
    end else begin
      lp_q      <= lp_d;
      sre_cnt_q <= sre_cnt_d;
      ign_q     <= ign_d;
    end
  end

  // ----------------------------------------
  // dll reset and lock
  // ----------------------------------------
  logic [9:0] lock_cnt_q, lock_cnt_d;
  logic       locked_q, locked_d;

  always_comb begin
    lock_cnt_d = lock_cnt_q;
    locked_d   = locked_q;
    if (dll_off_d) begin
      // drop any count in flight so the dll only relocks after a fresh reset
      lock_cnt_d = 10'h0;
      locked_d   = 1'b0;
    end else if (dll_rst_start) begin
      lock_cnt_d = TDLLK_NCK;
      locked_d   = 1'b0;
    end else if (!locked_q && (lock_cnt_q != 10'h0) && ck_rise && !ign_q) begin
      lock_cnt_d = lock_cnt_q - 10'h1;
      locked_d   = (lock_cnt_q == 10'h1);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lock_cnt_q <= 10'h0;
      locked_q   <= 1'b0;
    end else begin
      lock_cnt_q <= lock_cnt_d;
      locked_q   <= locked_d;
    end
  end

  // ----------------------------------------
  // read strobe window
  // ----------------------------------------
  logic [4:0] rd_cnt_q, rd_cnt_d, al_val, rd_target;
  logic       rd_busy_q, rd_busy_d, rd_win_q, rd_win_d;

  always_comb begin
    unique case (al_code_q)
      AL_CL_M1: al_val = {1'b0, cl_q} - 5'h01;
      AL_CL_M2: al_val = {1'b0, cl_q} - 5'h02;
      default:  al_val = 5'h00;
    endcase
    rd_target = al_val + {1'b0, cl_q} - {4'h0, dll_off_q};
    rd_cnt_d  = rd_cnt_q;
    rd_busy_d = rd_busy_q;
    rd_win_d  = 1'b0;
    if (read_cmd) begin
      rd_cnt_d  = rd_target;
      rd_busy_d = 1'b1;
    end else if (rd_busy_q && ck_rise) begin
      rd_cnt_d = rd_cnt_q - 5'h01;
      if (rd_cnt_q == 5'h01) begin
        rd_busy_d = 1'b0;
        rd_win_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_cnt_q  <= 5'h00;
      rd_busy_q <= 1'b0;
      rd_win_q  <= 1'b0;
    end else begin
      rd_cnt_q  <= rd_cnt_d;
      rd_busy_q <= rd_busy_d;
      rd_win_q  <= rd_win_d;
    end
  end

  // ----------------------------------------
  // write leveling feedback and termination
  // ----------------------------------------
  logic [15:0] dq_q, dq_d;
  logic        dq_term_q, dq_term_d, dqs_term_q, dqs_term_d, rtt_en;

  assign rtt_en = (rtt_q != 3'h0);

  always_comb begin
    dq_d = dq_q;
    if (!wl_q) begin
      dq_d = 16'h0000;
    end else begin
      // prime bit per lane, the other bits stay low
      if (dqsl_rise) begin
        dq_d[0] = ck_lvl;
      end
      if (dqsu_rise) begin
        dq_d[8] = ck_lvl;
      end
    end
    // direct termination is unsupported with the dll off
    dq_term_d  = !wl_q && odt_lvl && rtt_en && !dll_off_q && (lp_q != LP_SELF_REFRESH);
    dqs_term_d = wl_q ? odt_lvl : dq_term_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dq_q       <= 16'h0000;
      dq_term_q  <= 1'b0;
      dqs_term_q <= 1'b0;
    end else begin
      dq_q       <= dq_d;
      dq_term_q  <= dq_term_d;
      dqs_term_q <= dqs_term_d;
    end
  end

  assign dq_o              = dq_q;
  assign dq_oe_n           = !(wl_q && !qoff_q);
  assign dll_enabled       = !dll_off_q;
  assign dll_locked        = locked_q;
  assign latency_error     = lat_err_q;
  assign leveling_active   = wl_q;
  assign clock_ignored     = ign_q;
  assign dq_term_on        = dq_term_q;
  assign dqs_term_on       = dqs_term_q;
  assign read_window_start = rd_win_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] h_exp_q, h_seen_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      h_exp_q  <= 5'h00;
      h_seen_q <= 5'h00;
    end else if (read_cmd) begin
      h_exp_q  <= rd_target;
      h_seen_q <= 5'h00;
    end else if (rd_busy_q && ck_rise) begin
      h_seen_q <= h_seen_q + 5'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  dll_off_write_a: assert property (mr1_wr |=> dll_off_q == $past(mrs_addr[DLL_OFF_BIT]))
    else $error("dll mode not taken from mode write");
  dll_off_hold_a: assert property (!mr1_wr |=> $stable(dll_off_q))
    else $error("dll mode changed without mode write");
  latency_flag_a: assert property (dll_off_q && (cl_q != CL_DLL_OFF) |-> latency_error)
    else $error("unsupported latency not flagged");
  read_window_a: assert property (rd_win_q |-> h_seen_q == h_exp_q)
    else $error("read window at wrong clock count");
  dll_reset_a: assert property (dll_rst_start && !mr1_wr && !dll_off_q |=> !locked_q && lock_cnt_q == TDLLK_NCK)
    else $error("dll reset not started");
  clock_ignore_a: assert property (lp_q == LP_ACTIVE ##1 lp_q == LP_ACTIVE |-> !clock_ignored)
    else $error("clock ignored while active");
  pd_term_off_a: assert property (lp_q == LP_POWER_DOWN && !rtt_en |=> !dq_term_on)
    else $error("termination on in power-down");
  wl_lower_a: assert property (wl_q && wl_d && dqsl_rise |=> dq_o[0] == $past(ck_lvl))
    else $error("lower lane feedback wrong");
  wl_upper_a: assert property (wl_q && wl_d && dqsu_rise |=> dq_o[8] == $past(ck_lvl))
    else $error("upper lane feedback wrong");
  wl_term_a: assert property (wl_q |=> !dq_term_on && (dqs_term_on == $past(odt_lvl)))
    else $error("leveling termination wrong");
  wl_entry_a: assert property (mr1_wr |=> leveling_active == $past(mrs_addr[WL_EN_BIT]))
    else $error("leveling mode not taken");

  cover_dll_off_read_c: cover property (dll_off_q && read_cmd ##[1:300] rd_win_q);
  cover_relock_c:       cover property (!locked_q ##1 locked_q);
  cover_level_c:        cover property (wl_q && dqsl_rise ##1 dq_o[0]);
  cover_sr_ignore_c:    cover property (lp_q == LP_SELF_REFRESH && clock_ignored);
endmodule

// ---- dv/mc_model.sv ----
// behavioural memory controller driving the clock, strobe, cke and odt pins
// assumes the bench calls its tasks in a legal order and only retimes ck in low power
`timescale 1ns/1ps
module mc_model (
  input  wire logic clock,
  output logic      ck_pin,
  output logic      cke_pin,
  output logic      odt_pin,
  output logic      dqs_l_pin,
  output logic      dqs_u_pin
);
  int ck_half = 400;

  // ----------------------------------------
  // device clock
  // ----------------------------------------
  // ck runs free at a fixed period; only retime changes it
  initial begin
    ck_pin = 1'b0;
    cke_pin = 1'b1;
    odt_pin = 1'b0;
    dqs_l_pin = 1'b0;
    dqs_u_pin = 1'b0;
    forever #(ck_half) ck_pin = ~ck_pin;
  end

  // ----------------------------------------
  // pin tasks
  // ----------------------------------------
  task automatic set_pins(input logic cke, input logic odt);
    @(posedge clock);
    #1;
    cke_pin = cke;
    odt_pin = odt;
  endtask

  // called only while the device ignores ck, any slower rate allowed
  task automatic retime(input int half);
    ck_half = half;
  endtask

  // one strobe rise placed mid-phase so both synchronisers agree on ck
  task automatic strobe(input logic lane, input logic ck_high);
    if (ck_high) begin
      @(posedge ck_pin);
    end else begin
      @(negedge ck_pin);
    end
    #200;
    if (lane) begin
      dqs_u_pin = 1'b1;
    end else begin
      dqs_l_pin = 1'b1;
    end
    #400;
    dqs_l_pin = 1'b0;
    dqs_u_pin = 1'b0;
  endtask
endmodule

// ---- dv/dll_mode_and_clock_change_control_bench.sv ----
// self-checking bench for the dll mode, clock change and write leveling block
// assumes mc_model plays the controller pins; dq input unused by the block
`timescale 1ns/1ps
module dll_mode_and_clock_change_control_bench;
  import dll_ctrl_pkg::*;
  logic              clock;
  logic              sys_rst;
  logic              mrs_valid;
  logic [1:0]        mrs_sel;
  logic [ADDR_W-1:0] mrs_addr;
  logic              sre_cmd;
  logic              read_cmd;
  logic [15:0]       dq_i;
  logic [15:0]       dq_o;
  logic              ck_pin, cke_pin, odt_pin, dqs_l_pin, dqs_u_pin;
  logic              dq_oe_n, dll_enabled, dll_locked, latency_error, leveling_active;
  logic              clock_ignored, dq_term_on, dqs_term_on, read_window_start;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                ck_rises = 0;
  wire logic [8:0]   status = {dll_enabled, dll_locked, latency_error, leveling_active, clock_ignored,
                               dq_term_on, dqs_term_on, read_window_start, dq_oe_n};

  mc_model ctl_u (.clock(clock), .ck_pin(ck_pin), .cke_pin(cke_pin), .odt_pin(odt_pin),
                  .dqs_l_pin(dqs_l_pin), .dqs_u_pin(dqs_u_pin));

  dll_mode_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .mrs_valid(mrs_valid), .mrs_sel(mrs_sel),
    .mrs_addr(mrs_addr), .sre_cmd(sre_cmd), .read_cmd(read_cmd), .ck_pin(ck_pin), .cke_pin(cke_pin),
    .odt_pin(odt_pin), .dqs_l_pin(dqs_l_pin), .dqs_u_pin(dqs_u_pin), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_n(dq_oe_n), .dll_enabled(dll_enabled), .dll_locked(dll_locked), .latency_error(latency_error),
    .leveling_active(leveling_active), .clock_ignored(clock_ignored), .dq_term_on(dq_term_on),
    .dqs_term_on(dqs_term_on), .read_window_start(read_window_start));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic mrs(input logic [1:0] sel, input logic [ADDR_W-1:0] addr);
    tick(1);
    mrs_valid = 1'b1;
    mrs_sel = sel;
    mrs_addr = addr;
    tick(1);
    mrs_valid = 1'b0;
    tick(1);
  endtask

  // lets the last ck rise clear the synchroniser so no count straddles a command
  task automatic align_ck;
    @(posedge ck_pin);
    tick(5);
  endtask

  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("reset status", 16'h0101, 16'(status));
    chk("reset dq", 16'h0000, dq_o);
  endtask

  task automatic t_latency;
    mrs(MR1_SEL, 13'h001);
    chk("dll off", 16'h0, 16'(dll_enabled));
    mrs(MR0_SEL, 13'h030);
    chk("cl seven off", 16'h1, 16'(latency_error));
    mrs(MR0_SEL, 13'h020);
    mrs(2'h3, 13'h000);
    chk("cl six off", 16'h0, 16'({dll_enabled, latency_error}));
    mrs(MR2_SEL, 13'h010);
    chk("cwl seven off", 16'h1, 16'(latency_error));
    mrs(MR1_SEL, 13'h000);
    chk("dll on", 16'h2, 16'({dll_enabled, latency_error}));
    mrs(MR2_SEL, 13'h008);
  endtask

  // al off or cl-1, dll on or off; cl and cwl stay at six
  task automatic t_read;
    int n0;
    int w;
    int exp;
    for (int i = 0; i < 4; i++) begin
      mrs(MR1_SEL, (i[1] ? 13'h008 : 13'h000) | (i[0] ? 13'h001 : 13'h000));
      exp = (i[1] ? 11 : 6) - i[0];
      align_ck;
      n0 = ck_rises;
      read_cmd = 1'b1;
      tick(1);
      read_cmd = 1'b0;
      w = 0;
      while (read_window_start !== 1'b1 && w < 300) begin
        tick(1);
        w++;
      end
      chk("read window ck rises", 16'(exp), 16'(ck_rises - n0));
    end
    mrs(MR1_SEL, 13'h000);
  endtask

  task automatic t_lock;
    int n0;
    int w;
    align_ck;
    n0 = ck_rises;
    mrs(MR0_SEL, 13'h120);
    w = 0;
    while (dll_locked !== 1'b1 && w < 6000) begin
      tick(1);
      w++;
    end
    chk("lock ck rises", 16'(TDLLK_NCK), 16'(ck_rises - n0));
    mrs(MR1_SEL, 13'h001);
    chk("lock drop", 16'h0, 16'(dll_locked));
    mrs(MR1_SEL, 13'h000);
  endtask

  task automatic t_power;
    mrs(MR1_SEL, 13'h004);
    ctl_u.set_pins(1'b1, 1'b1);
    tick(6);
    chk("term active", 16'h3, 16'({dq_term_on, dqs_term_on}));
    ctl_u.set_pins(1'b0, 1'b0);
    tick(6);
    chk("pd ignored", 16'h1, 16'(clock_ignored));
    ctl_u.retime(600);
    repeat (4) @(posedge ck_pin);
    ctl_u.retime(400);
    repeat (2) @(posedge ck_pin);
    ctl_u.set_pins(1'b1, 1'b0);
    tick(6);
    chk("pd exit", 16'h0, 16'(clock_ignored));
    mrs(MR1_SEL, 13'h000);
    ctl_u.set_pins(1'b0, 1'b1);
    tick(6);
    chk("pd rtt off", 16'h1, 16'({dq_term_on, clock_ignored}));
    ctl_u.set_pins(1'b1, 1'b0);
    tick(6);
    mrs(MR0_SEL, 13'h120);
    // dll goes off before self-refresh and back on after it; termination is already off
    mrs(MR1_SEL, 13'h001);
    sre_cmd = 1'b1;
    tick(1);
    sre_cmd = 1'b0;
    ctl_u.set_pins(1'b0, 1'b0);
    tick(3);
    chk("sr ignored", 16'h1, 16'(clock_ignored));
    ctl_u.retime(1000);
    repeat (3) @(posedge ck_pin);
    ctl_u.retime(400);
    repeat (2) @(posedge ck_pin);
    ctl_u.set_pins(1'b1, 1'b0);
    tick(6);
    chk("sr exit", 16'h0, 16'(clock_ignored));
    mrs(MR1_SEL, 13'h000);
    chk("sr dll on", 16'h1, 16'(dll_enabled));
  endtask

  task automatic t_level;
    mrs(MR1_SEL, 13'h084);
    chk("wl enter", 16'h2, 16'({leveling_active, dq_oe_n}));
    ctl_u.set_pins(1'b1, 1'b1);
    tick(6);
    chk("wl term", 16'h1, 16'({dq_term_on, dqs_term_on}));
    ctl_u.strobe(1'b0, 1'b1);
    ctl_u.strobe(1'b1, 1'b0);
    tick(8);
    chk("wl lanes a", 16'h0001, dq_o);
    ctl_u.strobe(1'b0, 1'b0);
    ctl_u.strobe(1'b1, 1'b1);
    tick(8);
    chk("wl lanes b", 16'h0100, dq_o);
    mrs(MR1_SEL, 13'h1084);
    chk("wl output off", 16'h1, 16'(dq_oe_n));
    ctl_u.set_pins(1'b1, 1'b0);
    mrs(MR1_SEL, 13'h000);
    chk("wl exit", 16'h1, 16'({leveling_active, dq_oe_n}));
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge ck_pin) ck_rises++;

  // whole run needs about 5000 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end

  initial begin
    sys_rst = 1'b1;
    mrs_valid = 1'b0;
    mrs_sel = 2'h0;
    mrs_addr = 13'h000;
    sre_cmd = 1'b0;
    read_cmd = 1'b0;
    dq_i = 16'h0000;
    repeat (4) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    tick(1);
    t_reset;
    t_latency;
    t_read;
    t_power;
    t_lock;
    t_level;
    close_out;
  end
endmodule
